// ===== idts_top.sv
`timescale 1ns/1ns
// Function
// - half carry is carry out of bit three
// - tested flags follow condition, others hold
// - product: 11 cycles, unsigned, z and c
// - sign widen: 2 cycles, b sign fills a
// - system/user saves are 2 bytes, flags kept
// - system/user restores are 2 bytes
// - stack ops: 5 cycles plus one per byte
// - first trap: 19 cycles, sets both masks
// - paged traps: 20 cycles, masks untouched
// - register copy: 6 cycles, matching widths
// - 8-bit and 16-bit register sets defined
// - indexed mode adds extra cycles and bytes
// - long conditional branch 5 or 6 cycles
// - half carry undefined after negate, subtract
// - flag set ors into flags, trap return loads flags
// - 16-bit store high byte first, nz v0
// - operand check: 2 cycles, nz, v cleared
// - prefixes 10 and 11 select pages
module idts_top (
  input  wire logic        clk_i,      // 20 mhz clock
  input  wire logic        rst_i,      // synchronous reset, active high
  input  wire logic        cyc_i,      // wishbone cycle
  input  wire logic        stb_i,      // wishbone strobe
  input  wire logic        we_i,       // wishbone write
  input  wire logic [3:0]  adr_i,      // wishbone byte address
  input  wire logic [3:0]  sel_i,      // wishbone byte selects
  input  wire logic [31:0] dat_i,      // wishbone write data
  output logic      [31:0] dat_o,      // wishbone read data
  output logic             ack_o,      // wishbone acknowledge
  output logic      [3:0]  class_o,    // decoded operation class
  output logic      [2:0]  mode_o,     // decoded addressing mode
  output logic      [4:0]  cycles_o,   // total cycle count
  output logic      [3:0]  bytes_o,    // total byte length
  output logic      [7:0]  fmask_o,    // flags the op may update
  output logic             illegal_o   // bad register pair or opcode
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] ctrl_q;     // taken flag, indexed extras
  logic [15:0] opc_q;      // prefix in high byte, opcode in low
  logic [7:0]  post_q;     // postbyte for stack and copy ops
  logic [7:0]  opa_q;      // accumulator a operand
  logic [7:0]  opb_q;      // accumulator b / memory operand
  logic [7:0]  flags_q;    // flag register
  logic [15:0] res_q;      // last arithmetic result
  logic        use_b_q;    // single operand select / paged trap
  logic        exec_q;     // one cycle pulse: apply flag update
  logic        ack_q;      // bus acknowledge
  logic [31:0] rdat_q;     // bus read data
  logic        bus_req;    // new access this cycle
  logic [15:0] alu_res;    // alu result
  logic [7:0]  alu_flags;  // alu flag result

  ////////////////////////////////////////////////////////////////////////
  // decode signals
  idts_pkg::idts_class_t cls_d;   // decoded class
  idts_pkg::idts_mode_t  mode_d;  // decoded mode
  logic [4:0] cyc_d;              // total cycles
  logic [3:0] byt_d;              // total bytes
  logic [7:0] fm_d;               // flag mask
  logic       bad_d;              // illegal indication
  logic [3:0] pcount;             // bytes moved by stack op
  logic       page2;              // second page selected
  logic       page3;              // third page selected
  logic       src16;              // copy source is 16-bit
  logic       dst16;              // copy destination is 16-bit
  logic       srcok;              // copy source code valid
  logic       dstok;              // copy destination code valid
  logic [7:0] op;                 // opcode byte

  assign op = opc_q[7:0];
  assign page2 = (opc_q[15:8] == idts_pkg::PFX_PAGE2);
  assign page3 = (opc_q[15:8] == idts_pkg::PFX_PAGE3);

  // per bit stack byte count: pc,u/s,y,x take two, others one
  logic [3:0] pbits [8];
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_cnt
      if (g == 0) begin : g_first
        assign pbits[g] = {3'h0, post_q[g]};
      end else begin : g_next
        assign pbits[g] = pbits[g-1] + ((g >= 4) ? {2'h0, post_q[g], 1'b0}
                                                 : {3'h0, post_q[g]});
      end
    end
  endgenerate
  assign pcount = pbits[7];

  // register codes: 0-5 are 16-bit, 8-b are 8-bit
  assign src16 = ~post_q[7];
  assign dst16 = ~post_q[3];
  assign srcok = post_q[7] ? (post_q[6:4] <= 3'h3) : (post_q[6:4] <= 3'h5);
  assign dstok = post_q[3] ? (post_q[2:0] <= 3'h3) : (post_q[2:0] <= 3'h5);

  ////////////////////////////////////////////////////////////////////////
  // opcode decode
  always_comb begin
    cls_d = idts_pkg::CL_BAD;
    mode_d = idts_pkg::AM_INH;
    cyc_d = idts_pkg::CYC_TWO;
    byt_d = 4'h1;
    fm_d = 8'h00;
    bad_d = 1'b0;
    if (page2 || page3) begin
      byt_d = 4'h2;
      if (op == idts_pkg::OP_TRAP) begin
        cls_d = idts_pkg::CL_TRAP;
        cyc_d = idts_pkg::CYC_TRAP23;
      end else if (page2 && op[7:4] == 4'h2 && op[3:0] != 4'h0) begin
        cls_d = idts_pkg::CL_LBR;
        mode_d = idts_pkg::AM_REL;
        byt_d = 4'h4;
        cyc_d = idts_pkg::CYC_LBR + {4'h0, ctrl_q[idts_pkg::CTRL_BRTAKEN]
                                    & (op != 8'h21)};
      end else begin
        bad_d = 1'b1;
      end
    end else begin
      unique case (op)
        idts_pkg::OP_PRODUCT: begin
          cls_d = idts_pkg::CL_PROD;
          cyc_d = idts_pkg::CYC_PRODUCT;
          fm_d = 8'h05;
        end
        idts_pkg::OP_SIGNW: begin
          cls_d = idts_pkg::CL_SIGNW;
          fm_d = 8'h0e;
        end
        idts_pkg::OP_SSAVE, idts_pkg::OP_USAVE: begin
          cls_d = idts_pkg::CL_SAVE;
          mode_d = idts_pkg::AM_IMM;
          byt_d = 4'h2;
          cyc_d = idts_pkg::CYC_STACK + {1'b0, pcount};
        end
        idts_pkg::OP_SREST, idts_pkg::OP_UREST: begin
          cls_d = idts_pkg::CL_REST;
          mode_d = idts_pkg::AM_IMM;
          byt_d = 4'h2;
          cyc_d = idts_pkg::CYC_STACK + {1'b0, pcount};
          fm_d = {7'h00, post_q[0]} * 8'hff;
        end
        idts_pkg::OP_TRAP: begin
          cls_d = idts_pkg::CL_TRAP;
          cyc_d = idts_pkg::CYC_TRAP1;
          fm_d = 8'h50;
        end
        idts_pkg::OP_COPY, idts_pkg::OP_SWAP: begin
          cls_d = (op == idts_pkg::OP_COPY) ? idts_pkg::CL_COPY
                                            : idts_pkg::CL_SWAP;
          mode_d = idts_pkg::AM_IMM;
          byt_d = 4'h2;
          cyc_d = (op == idts_pkg::OP_COPY) ? idts_pkg::CYC_COPY
                                            : idts_pkg::CYC_SWAP;
          bad_d = (src16 != dst16) || !srcok || !dstok;
        end
        idts_pkg::OP_FLAGSET: begin
          cls_d = idts_pkg::CL_FSET;
          mode_d = idts_pkg::AM_IMM;
          byt_d = 4'h2;
          cyc_d = idts_pkg::CYC_FLAGSET;
          fm_d = 8'hff;
        end
        idts_pkg::OP_TRET: begin
          cls_d = idts_pkg::CL_TRET;
          cyc_d = idts_pkg::CYC_TRET;
          fm_d = 8'hff;
        end
        idts_pkg::OP_CHECKA, idts_pkg::OP_CHECKB: begin
          cls_d = idts_pkg::CL_CHECK;
          fm_d = 8'h0e;
        end
        idts_pkg::OP_INVA, idts_pkg::OP_INVB: begin
          cls_d = idts_pkg::CL_INV;
          fm_d = 8'h0f;
        end
        idts_pkg::OP_SUB_IMM, idts_pkg::OP_SBC_IMM: begin
          cls_d = idts_pkg::CL_SUB;
          mode_d = idts_pkg::AM_IMM;
          byt_d = 4'h2;
          fm_d = 8'h2f;
        end
        idts_pkg::OP_DST_DIR: begin
          cls_d = idts_pkg::CL_STORE;
          mode_d = idts_pkg::AM_DIR;
          byt_d = 4'h2;
          cyc_d = idts_pkg::CYC_DST_DIR;
          fm_d = 8'h0e;
        end
        idts_pkg::OP_DST_IDX: begin
          cls_d = idts_pkg::CL_STORE;
          mode_d = idts_pkg::AM_IDX;
          byt_d = 4'h2 + ctrl_q[idts_pkg::CTRL_IDX_BYT +: 4];
          cyc_d = idts_pkg::CYC_DST_IDX
                  + {1'b0, ctrl_q[idts_pkg::CTRL_IDX_CYC +: 4]};
          fm_d = 8'h0e;
        end
        idts_pkg::OP_DST_EXT: begin
          cls_d = idts_pkg::CL_STORE;
          mode_d = idts_pkg::AM_EXT;
          byt_d = 4'h3;
          cyc_d = idts_pkg::CYC_DST_EXT;
          fm_d = 8'h0e;
        end
        default: begin
          bad_d = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alu instance
  idts_alu u_alu (
    .cls_i   (cls_d),
    .opa_i   (opa_q),
    .opb_i   (opb_q),
    .flags_i (flags_q),
    .use_b_i (use_b_q),
    .res_o   (alu_res),
    .flags_o (alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait cycle
  assign bus_req = cyc_i && stb_i && !ack_q;

  // acknowledge one cycle after request, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= idts_pkg::CTRL_RESET;
      opc_q <= 16'h0000;
      post_q <= 8'h00;
      opa_q <= 8'h00;
      opb_q <= 8'h00;
      use_b_q <= 1'b0;
    end else if (bus_req && we_i) begin
      unique case (adr_i)
        idts_pkg::REG_CTRL: begin
          if (sel_i[0]) ctrl_q[7:0] <= dat_i[7:0];
          if (sel_i[1]) ctrl_q[15:8] <= dat_i[15:8];
        end
        idts_pkg::REG_OPCODE: begin
          if (sel_i[0]) opc_q[7:0] <= dat_i[7:0];
          if (sel_i[1]) opc_q[15:8] <= dat_i[15:8];
          if (sel_i[2]) post_q <= dat_i[23:16];
          if (sel_i[3]) use_b_q <= dat_i[24];
        end
        idts_pkg::REG_ALU: begin
          if (sel_i[0]) opa_q <= dat_i[7:0];
          if (sel_i[1]) opb_q <= dat_i[15:8];
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end
  end

  // execute pulse after a write of the opcode register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exec_q <= 1'b0;
    end else begin
      exec_q <= bus_req && we_i && (adr_i == idts_pkg::REG_OPCODE);
    end
  end

  // flag register and result update, masked by decoded class
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= 8'h00;
      res_q <= 16'h0000;
    end else if (bus_req && we_i && adr_i == idts_pkg::REG_ALU
                 && sel_i[2]) begin
      flags_q <= dat_i[23:16];
    end else if (exec_q && !bad_d) begin
      flags_q <= alu_flags;
      res_q <= alu_res;
    end
  end

  // read data mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h00000000;
    end else if (bus_req && !we_i) begin
      unique case (adr_i)
        idts_pkg::REG_CTRL:   rdat_q <= {16'h0000, ctrl_q};
        idts_pkg::REG_OPCODE: rdat_q <= {7'h00, use_b_q, post_q, opc_q};
        idts_pkg::REG_RESULT: rdat_q <= {5'h00, fm_d, bad_d, 2'h0, byt_d,
                                         mode_d, cyc_d, cls_d};
        idts_pkg::REG_ALU:    rdat_q <= {res_q[15:8], flags_q, res_q[7:0],
                                         opa_q};
        default:              rdat_q <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered decode outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      class_o <= 4'h0;
      mode_o <= 3'h0;
      cycles_o <= 5'h00;
      bytes_o <= 4'h0;
      fmask_o <= 8'h00;
      illegal_o <= 1'b0;
    end else begin
      class_o <= cls_d;
      mode_o <= mode_d;
      cycles_o <= cyc_d;
      bytes_o <= byt_d;
      fmask_o <= fm_d;
      illegal_o <= bad_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;
endmodule

// ===== idts_pkg.sv
package idts_pkg;
  // wishbone register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0; // control: branch taken, indexed extras
  localparam logic [3:0] REG_OPCODE = 4'h4; // opcode plus prefix byte
  localparam logic [3:0] REG_RESULT = 4'h8; // decoded class, mode, counts
  localparam logic [3:0] REG_ALU    = 4'hc; // operands, flags, result
  // control field positions
  localparam int CTRL_BRTAKEN = 0; // branch taken for long conditionals
  localparam int CTRL_IDX_CYC = 8; // indexed extra cycles, 4 bits
  localparam int CTRL_IDX_BYT = 12; // indexed extra bytes, 4 bits
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // prefixes selecting opcode pages
  localparam logic [7:0] PFX_PAGE2 = 8'h10;
  localparam logic [7:0] PFX_PAGE3 = 8'h11;
  // opcodes of this subset
  localparam logic [7:0] OP_PRODUCT  = 8'h3d;
  localparam logic [7:0] OP_SIGNW    = 8'h1d;
  localparam logic [7:0] OP_SSAVE    = 8'h34;
  localparam logic [7:0] OP_SREST    = 8'h35;
  localparam logic [7:0] OP_USAVE    = 8'h36;
  localparam logic [7:0] OP_UREST    = 8'h37;
  localparam logic [7:0] OP_TRAP     = 8'h3f;
  localparam logic [7:0] OP_COPY     = 8'h1f;
  localparam logic [7:0] OP_SWAP     = 8'h1e;
  localparam logic [7:0] OP_FLAGSET  = 8'h1a;
  localparam logic [7:0] OP_TRET     = 8'h3b;
  localparam logic [7:0] OP_CHECKA   = 8'h4d;
  localparam logic [7:0] OP_CHECKB   = 8'h5d;
  localparam logic [7:0] OP_INVA     = 8'h40;
  localparam logic [7:0] OP_INVB     = 8'h50;
  localparam logic [7:0] OP_DST_DIR  = 8'hdd;
  localparam logic [7:0] OP_DST_IDX  = 8'hed;
  localparam logic [7:0] OP_DST_EXT  = 8'hfd;
  localparam logic [7:0] OP_SBC_IMM  = 8'h82;
  localparam logic [7:0] OP_SUB_IMM  = 8'h80;
  // base cycle counts
  localparam logic [4:0] CYC_PRODUCT = 5'd11;
  localparam logic [4:0] CYC_TWO     = 5'd2;
  localparam logic [4:0] CYC_STACK   = 5'd5;
  localparam logic [4:0] CYC_TRAP1   = 5'd19;
  localparam logic [4:0] CYC_TRAP23  = 5'd20;
  localparam logic [4:0] CYC_COPY    = 5'd6;
  localparam logic [4:0] CYC_SWAP    = 5'd8;
  localparam logic [4:0] CYC_FLAGSET = 5'd3;
  localparam logic [4:0] CYC_TRET    = 5'd6;
  localparam logic [4:0] CYC_LBR     = 5'd5;
  localparam logic [4:0] CYC_DST_DIR = 5'd5;
  localparam logic [4:0] CYC_DST_IDX = 5'd5;
  localparam logic [4:0] CYC_DST_EXT = 5'd6;
  // flag register bit positions
  localparam int F_C = 0;
  localparam int F_V = 1;
  localparam int F_Z = 2;
  localparam int F_N = 3;
  localparam int F_I = 4;
  localparam int F_H = 5;
  localparam int F_F = 6;
  // operation classes
  typedef enum logic [3:0] {
    CL_NONE  = 4'h0, CL_PROD  = 4'h1, CL_SIGNW = 4'h2, CL_SAVE  = 4'h3,
    CL_REST  = 4'h4, CL_TRAP  = 4'h5, CL_COPY  = 4'h6, CL_SWAP  = 4'h7,
    CL_FSET  = 4'h8, CL_TRET  = 4'h9, CL_CHECK = 4'ha, CL_INV   = 4'hb,
    CL_STORE = 4'hc, CL_SUB   = 4'hd, CL_LBR   = 4'he, CL_BAD   = 4'hf
  } idts_class_t;
  // addressing modes
  typedef enum logic [2:0] {
    AM_INH = 3'h0, AM_IMM = 3'h1, AM_DIR = 3'h2, AM_IDX = 3'h3,
    AM_EXT = 3'h4, AM_REL = 3'h5
  } idts_mode_t;
endpackage

// ===== idts_alu.sv
`timescale 1ns/1ns
// flag computation for the arithmetic part of the subset
module idts_alu (
  input  wire logic [3:0]  cls_i,      // operation class
  input  wire logic [7:0]  opa_i,      // accumulator a
  input  wire logic [7:0]  opb_i,      // accumulator b or operand
  input  wire logic [7:0]  flags_i,    // current flag register
  input  wire logic        use_b_i,    // select b as single operand
  output logic      [15:0] res_o,      // result value
  output logic      [7:0]  flags_o     // updated flag register
);
  logic [8:0] sum;   // 8-bit difference with borrow
  logic [4:0] lo;    // low nibble difference
  logic [7:0] x;     // single operand
  // combinational result and flag update
  always_comb begin
    sum = 9'h000;
    lo = 5'h00;
    x = use_b_i ? opb_i : opa_i;
    res_o = 16'h0000;
    flags_o = flags_i;
    unique case (cls_i)
      4'h1: begin // product, unsigned
        res_o = {8'h00, opa_i} * {8'h00, opb_i};
        flags_o[idts_pkg::F_Z] = (res_o == 16'h0000);
        flags_o[idts_pkg::F_C] = res_o[7];
      end
      4'h2: begin // sign widen b into a
        res_o = {{8{opb_i[7]}}, opb_i};
        flags_o[idts_pkg::F_N] = res_o[15];
        flags_o[idts_pkg::F_Z] = (res_o == 16'h0000);
        flags_o[idts_pkg::F_V] = 1'b0;
      end
      4'ha: begin // operand check, operand untouched
        res_o = {8'h00, x};
        flags_o[idts_pkg::F_N] = x[7];
        flags_o[idts_pkg::F_Z] = (x == 8'h00);
        flags_o[idts_pkg::F_V] = 1'b0;
      end
      4'hb: begin // twos invert, half carry left as is
        sum = 9'h000 - {1'b0, x};
        res_o = {8'h00, sum[7:0]};
        flags_o[idts_pkg::F_N] = sum[7];
        flags_o[idts_pkg::F_Z] = (sum[7:0] == 8'h00);
        flags_o[idts_pkg::F_V] = (x == 8'h80);
        flags_o[idts_pkg::F_C] = (x != 8'h00);
      end
      4'hd: begin // subtract / borrow subtract a - b - c
        lo = {1'b0, opa_i[3:0]} - {1'b0, opb_i[3:0]}
             - {4'h0, flags_i[idts_pkg::F_C] & use_b_i};
        sum = {1'b0, opa_i} - {1'b0, opb_i}
              - {8'h00, flags_i[idts_pkg::F_C] & use_b_i};
        res_o = {8'h00, sum[7:0]};
        flags_o[idts_pkg::F_H] = lo[4];
        flags_o[idts_pkg::F_N] = sum[7];
        flags_o[idts_pkg::F_Z] = (sum[7:0] == 8'h00);
        flags_o[idts_pkg::F_V] = (opa_i[7] ^ opb_i[7]) & (opa_i[7] ^ sum[7]);
        flags_o[idts_pkg::F_C] = sum[8];
      end
      4'hc: begin // sixteen-bit store, high byte first
        res_o = {opa_i, opb_i};
        flags_o[idts_pkg::F_N] = opa_i[7];
        flags_o[idts_pkg::F_Z] = ({opa_i, opb_i} == 16'h0000);
        flags_o[idts_pkg::F_V] = 1'b0;
      end
      4'h8: begin // immediate flag set
        res_o = {8'h00, flags_i | opb_i};
        flags_o = flags_i | opb_i;
      end
      4'h9: begin // flags reloaded from stacked byte
        res_o = {8'h00, opb_i};
        flags_o = opb_i;
      end
      4'h5: begin // trap; masks set by first trap only
        flags_o[idts_pkg::F_I] = flags_i[idts_pkg::F_I] | ~use_b_i;
        flags_o[idts_pkg::F_F] = flags_i[idts_pkg::F_F] | ~use_b_i;
      end
      default: begin // not affected
        flags_o = flags_i;
      end
    endcase
  end
endmodule

// ===== idts_top_sva.sv
`timescale 1ns/1ns
// checker on the decoder's bus handshake and decode outputs
module idts_top_sva (
  input wire logic       clk_i,     // clock
  input wire logic       rst_i,     // synchronous reset
  input wire logic       cyc_i,     // bus cycle
  input wire logic       stb_i,     // bus strobe
  input wire logic       ack_o,     // bus acknowledge
  input wire logic [3:0] class_o,   // decoded class
  input wire logic [4:0] cycles_o,  // total cycles
  input wire logic [3:0] bytes_o,   // total bytes
  input wire logic [7:0] fmask_o,   // flags the op may touch
  input wire logic       illegal_o  // bad pair or opcode
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  // handshake and reset
  property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_ack_idle; !(cyc_i && stb_i) |=> !ack_o; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
  property p_rst_clr; $fell(rst_i) |-> class_o == 4'h0 && !ack_o; endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("reset value");
  // decode stays put while the bus is quiet
  property p_hold;
    !(cyc_i && stb_i) [*3] |=> $stable({class_o, cycles_o, bytes_o});
  endproperty
  a_hold: assert property (p_hold) else $error("decode drift");
  ////////////////////////////////////////////////////////////////////////
  // per class counts
  property p_prod; class_o == 4'h1 |-> cycles_o == 5'd11 && bytes_o == 4'h1;
  endproperty
  a_prod: assert property (p_prod) else $error("product counts");
  property p_signw; class_o == 4'h2 |-> cycles_o == 5'd2 && bytes_o == 4'h1;
  endproperty
  a_signw: assert property (p_signw) else $error("widen counts");
  property p_save;
    class_o == 4'h3 |-> bytes_o == 4'h2 && fmask_o == 8'h00
      && cycles_o inside {[5'd5:5'd17]};
  endproperty
  a_save: assert property (p_save) else $error("save counts");
  property p_rest;
    class_o == 4'h4 |-> bytes_o == 4'h2 && cycles_o inside {[5'd5:5'd17]};
  endproperty
  a_rest: assert property (p_rest) else $error("restore counts");
  property p_trap;
    class_o == 4'h5 |-> (cycles_o == 5'd19 && bytes_o == 4'h1)
      || (cycles_o == 5'd20 && bytes_o == 4'h2);
  endproperty
  a_trap: assert property (p_trap) else $error("trap counts");
  property p_copy;
    class_o == 4'h6 && !illegal_o |-> cycles_o == 5'd6 && bytes_o == 4'h2;
  endproperty
  a_copy: assert property (p_copy) else $error("copy counts");
  property p_check; class_o == 4'ha |-> cycles_o == 5'd2 && bytes_o == 4'h1;
  endproperty
  a_check: assert property (p_check) else $error("check counts");
  property p_lbr;
    class_o == 4'he |-> bytes_o == 4'h4 && cycles_o inside {5'd5, 5'd6};
  endproperty
  a_lbr: assert property (p_lbr) else $error("branch counts");
  // main scenarios seen
  c_prod: cover property (class_o == 4'h1);
  c_trap: cover property (class_o == 4'h5 && cycles_o == 5'd20);
  c_lbr: cover property (class_o == 4'he && cycles_o == 5'd6);
endmodule

bind idts_top idts_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .class_o(class_o),
  .cycles_o(cycles_o), .bytes_o(bytes_o), .fmask_o(fmask_o),
  .illegal_o(illegal_o));

// ===== idts_prog_mem.sv
`timescale 1ns/1ns
// program memory: one word per instruction {use_b, postbyte, prefix, op}
module idts_prog_mem (
  input  wire logic [4:0]  idx_i,  // instruction slot
  output logic      [31:0] word_o  // packed instruction bytes
);
  // instruction images in slot order
  logic [31:0] rom [22] = '{
    32'h3d, 32'h1d, 32'h00ff0034, 32'h00f00036, 32'h00010037, 32'h35,
    32'h3f, 32'h0100103f, 32'h0100113f, 32'h0089001f, 32'h0005001f,
    32'h0018001f, 32'h0089001e, 32'h1a, 32'h4d, 32'h0100005d, 32'hdd,
    32'hed, 32'h1026, 32'h1026, 32'h1021, 32'h3b};
  // empty slots read as all ones, never a stale word
  assign word_o = (idx_i < 5'd22) ? rom[idx_i] : 32'hffffffff;
endmodule

// ===== tb_isa_decode_tail_subset.sv
`timescale 1ns/1ns
module tb_isa_decode_tail_subset;
  logic        clk_i = 1'b0;  // 20 mhz clock
  logic        rst_i = 1'b1;  // reset
  logic        cyc_i = 1'b0;  // bus cycle
  logic        stb_i = 1'b0;  // bus strobe
  logic        we_i  = 1'b0;  // bus write
  logic [3:0]  adr_i = 4'h0;  // bus address
  logic [3:0]  sel_i = 4'hf;  // byte lanes
  logic [31:0] dat_i = 32'h0; // write data
  logic [31:0] dat_o;         // read data
  logic        ack_o;         // acknowledge
  logic [3:0]  class_o;       // decoded class
  logic [4:0]  cycles_o;      // cycles
  logic [2:0]  mode_o;        // addressing mode
  logic [7:0]  fmask_o;       // flag mask
  logic [3:0]  bytes_o;       // bytes
  logic        illegal_o;     // bad pair
  logic [4:0]  idx = 5'h0;    // memory slot
  logic [31:0] word;          // instruction word
  logic [31:0] rd_q;          // last read data
  logic [13:0] got;           // packed decode
  int          err_count = 0; // mismatches
  int          n_checks = 0;  // comparisons
  // expected {ctrl, illegal, bytes, cycles, class} per memory slot
  logic [29:0] ex [22] = '{
    {16'h0,1'b0,4'd1,5'd11,4'h1}, {16'h0,1'b0,4'd1,5'd2,4'h2},
    {16'h0,1'b0,4'd2,5'd17,4'h3}, {16'h0,1'b0,4'd2,5'd13,4'h3},
    {16'h0,1'b0,4'd2,5'd6,4'h4}, {16'h0,1'b0,4'd2,5'd5,4'h4},
    {16'h0,1'b0,4'd1,5'd19,4'h5}, {16'h0,1'b0,4'd2,5'd20,4'h5},
    {16'h0,1'b0,4'd2,5'd20,4'h5}, {16'h0,1'b0,4'd2,5'd6,4'h6},
    {16'h0,1'b0,4'd2,5'd6,4'h6}, {16'h0,1'b1,13'h0},
    {16'h0,1'b0,4'd2,5'd8,4'h7}, {16'h0,1'b0,4'd2,5'd3,4'h8},
    {16'h0,1'b0,4'd1,5'd2,4'ha}, {16'h0,1'b0,4'd1,5'd2,4'ha},
    {16'h0,1'b0,4'd2,5'd5,4'hc}, {16'h3200,1'b0,4'd5,5'd7,4'hc},
    {16'h0,1'b0,4'd4,5'd5,4'he}, {16'h1,1'b0,4'd4,5'd6,4'he},
    {16'h1,1'b0,4'd4,5'd5,4'he}, {16'h0,1'b0,4'd1,5'd6,4'h9}};
  // expected addressing mode per memory slot
  logic [2:0]  exm [22] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0,
    3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0, 3'h2, 3'h3, 3'h5, 3'h5,
    3'h5, 3'h0};
  always #25 clk_i = ~clk_i;
  idts_prog_mem u_mem (.idx_i(idx), .word_o(word));
  idts_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .class_o(class_o), .mode_o(mode_o),
    .cycles_o(cycles_o), .bytes_o(bytes_o), .fmask_o(fmask_o),
    .illegal_o(illegal_o));
  ////////////////////////////////////////////////////////////////////////
  // verdict and run end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // one classic bus cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("MISMATCH t=%0t bus timeout", $time);
      give_verdict();
    end
    rd_q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  // load operands and flags, run one op, read flags and result back
  task automatic alu(input logic [31:0] w, input logic [7:0] a, b, fl, efl,
                     input logic [16:0] er);
    wb(1'b1, idts_pkg::REG_ALU, {8'h0, fl, b, a});
    wb(1'b1, idts_pkg::REG_OPCODE, w);
    repeat (3) @(posedge clk_i);
    wb(1'b0, idts_pkg::REG_ALU, 32'h0);
    chk({24'h0, rd_q[23:16]}, {24'h0, efl}, "flags");
    if (er[16])
      chk({16'h0, rd_q[31:24], rd_q[15:8]}, {16'h0, er[15:0]}, "res");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // registers: unmapped, reset value, read back, read-only
    wb(1'b0, 4'h2, 32'h0);
    chk(rd_q, 32'h0, "unmapped");
    wb(1'b0, idts_pkg::REG_CTRL, 32'h0);
    chk(rd_q, {16'h0, idts_pkg::CTRL_RESET}, "ctrl reset");
    wb(1'b1, idts_pkg::REG_CTRL, 32'h0000f301);
    wb(1'b0, idts_pkg::REG_CTRL, 32'h0);
    chk(rd_q, 32'h0000f301, "ctrl");
    wb(1'b0, idts_pkg::REG_RESULT, 32'h0);
    got = rd_q[13:0];
    wb(1'b1, idts_pkg::REG_RESULT, 32'hffffffff);
    wb(1'b0, idts_pkg::REG_RESULT, 32'h0);
    chk({18'h0, rd_q[13:0]}, {18'h0, got}, "read only");
    $display("test registers done");
    // every opcode of the memory through the decoder
    for (int i = 0; i < 22; i++) begin
      idx = i[4:0];
      wb(1'b1, idts_pkg::REG_CTRL, {16'h0, ex[i][29:14]});
      wb(1'b1, idts_pkg::REG_OPCODE, word);
      repeat (3) @(posedge clk_i);
      got = ex[i][13] ? {illegal_o, 13'h0}
                      : {illegal_o, bytes_o, cycles_o, class_o};
      chk({18'h0, got}, {18'h0, ex[i][13:0]}, "decode");
      chk({29'h0, mode_o}, {29'h0, exm[i]}, "mode");
    end
    chk({24'h0, fmask_o}, 32'h000000ff, "fmask");
    $display("test decode done");
    // flag effects
    alu(32'h3d, 8'hff, 8'h80, 8'h0a, 8'h0b, 17'h17f80);
    alu(32'h3d, 8'h00, 8'h37, 8'h0b, 8'h0e, 17'h10000);
    alu(32'h1d, 8'h00, 8'h80, 8'h02, 8'h08, 17'h0);
    alu(32'h4d, 8'h00, 8'h80, 8'h0a, 8'h04, 17'h0);
    alu(32'h0100005d, 8'h00, 8'h80, 8'h04, 8'h08, 17'h0);
    alu(32'h3f, 8'h00, 8'h00, 8'h00, 8'h50, 17'h0);
    alu(32'h0100103f, 8'h00, 8'h00, 8'h10, 8'h10, 17'h0);
    alu(32'hdd, 8'h00, 8'h00, 8'h03, 8'h05, 17'h0);
    alu(32'hdd, 8'h80, 8'h00, 8'h00, 8'h08, 17'h0);
    alu(32'h80, 8'h10, 8'h01, 8'h00, 8'h20, 17'h1000f);
    alu(32'h01000082, 8'h00, 8'h00, 8'h01, 8'h29, 17'h100ff);
    alu(32'h40, 8'h80, 8'h00, 8'h00, 8'h0b, 17'h10080);
    alu(32'h1a, 8'h00, 8'h05, 8'h10, 8'h15, 17'h0);
    alu(32'h3b, 8'h00, 8'ha5, 8'h00, 8'ha5, 17'h0);
    $display("test flags done");
    give_verdict();
  end
endmodule
